// ==== dv/adc_input_scan_select_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
// ========================================
// scan select monitor
module scan_monitor #(parameter int unsigned NUM_INPUTS = 16) (
   // watched ports
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       ce_i,
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic       ack_o,
   input wire logic       conv_start_o,
   input wire logic [3:0] analog_input_n_o,
   input wire logic       low_reference_voltage_o,
   input wire logic       conv_done_i
);
   default clocking @(posedge clk_i); endclocking
   // a low clock enable freezes the block, so no step is due then
   default disable iff (rst_i || !ce_i);
   sequence s_req; cyc_i && stb_i && !ack_o; endsequence
   sequence s_conv; conv_start_o ##1 !conv_done_i; endsequence
   AST_ACK: assert property (s_req |=> ack_o ##1 !ack_o)
      else $error("ack is not one pulse after a request");
   AST_GAP: assert property (conv_start_o |=> !conv_start_o [*3])
      else $error("start pulses too close");
   AST_VREF: assert property (conv_start_o |->
      low_reference_voltage_o == (analog_input_n_o >= NUM_INPUTS))
      else $error("low reference flag wrong for slot");
   AST_PICK: assert property (
      $changed(analog_input_n_o) |=> conv_start_o)
      else $error("no start after input pick");
   AST_HOLD: assert property (s_conv |-> $stable(analog_input_n_o))
      else $error("input moved during conversion");
   AST_SETTLE: assert property (conv_start_o |->
      $stable(analog_input_n_o) && $stable(low_reference_voltage_o))
      else $error("input not settled at start");
endmodule // scan_monitor
bind adc_input_scan_select scan_monitor #(.NUM_INPUTS(NUM_INPUTS)) mon (
   .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .ack_o, .conv_start_o,
   .analog_input_n_o, .low_reference_voltage_o, .conv_done_i);
`default_nettype wire

// ==== dv/conv_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ========================================
// converter model: done after a variable delay
module conv_model (
   // clock, reset, handshake
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       conv_start_i,
   input  wire logic [3:0] delay_i,
   output var  logic       conv_done_o
);
   logic [4:0] left;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         left        <= 5'h00;
         conv_done_o <= 1'b0;
      end else if (conv_start_i) begin
         left        <= {1'b0, delay_i} + 5'h01;
         conv_done_o <= 1'b0;
      end else begin
         left        <= (left != 5'h00) ? left - 5'h01 : left;
         conv_done_o <= (left == 5'h01);
      end
   end
endmodule // conv_model
`default_nettype wire

// ==== dv/tb_adc_input_scan_select.sv ====
`timescale 1ns/10ps
`default_nettype none
// ========================================
// scan select bench
module tb_adc_input_scan_select;
   localparam int unsigned NIN = 12;
   localparam logic [15:0] CORNER [4] =
      '{16'h0001, 16'h8000, 16'hF000, 16'hFFFF};
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [3:0]  adr_i = 4'h0;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic        ce_i  = 1'b1;
   logic [7:0]  wraps = 8'h00;
   logic [3:0]  dly   = 4'h3;
   logic [3:0]  cur   = 4'hF;
   logic [15:0] mask  = 16'h0;
   logic [31:0] seed  = 32'h32E64CD1;
   logic [31:0] dat_o, rd;
   logic [3:0]  ch;
   logic        ack_o, start, vref, done;
   int          fails = 0, samples_checked = 0, starts = 0;
   initial forever #2.5 clk_i = ~clk_i;
   adc_input_scan_select #(.NUM_INPUTS(NIN)) uut (.clk_i, .rst_i, .ce_i,
      .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .conv_start_o(start), .analog_input_n_o(ch),
      .low_reference_voltage_o(vref), .conv_done_i(done));
   conv_model cm (.clk_i, .rst_i, .conv_start_i(start), .delay_i(dly),
      .conv_done_o(done));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // next selected input above c, wrapping
   function automatic logic [3:0] nxt(input logic [15:0] m,
                                      input logic [3:0]  c);
      for (int i = 0; i < 16; i++) begin
         c = c + 4'h1;
         if (m[c]) return c;
      end
      return c;
   endfunction
   task automatic stop_test;
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      int t;
      t = 0;
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
      do begin
         @(posedge clk_i);
         t++;
      end while (ack_o !== 1'b1 && t < 50);
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
      if (t == 50) begin
         fails++;
         stop_test;
      end
      @(posedge clk_i);
   endtask
   // skipped inputs would break the expected order
   always @(posedge clk_i) begin
      if (start === 1'b1) begin
         cur = nxt(mask, cur);
         chk(32'(ch), 32'(cur));
         chk(32'(vref), 32'(cur >= NIN));
         starts++;
         dly <= dly + ch + 4'h5;
      end
      // a done whose next pick is not above it closes one round
      if (done === 1'b1 && nxt(mask, cur) <= cur)
         wraps <= wraps + 8'h01;
   end
   initial begin
      int n, k;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, scan_pkg::SCAN_SELECT_LOW_OFS, 4'hF, 32'h0);
      chk(rd, {16'h0, scan_pkg::SCAN_SELECT_RESET});
      wb(1'b0, scan_pkg::SCAN_STATUS_OFS, 4'hF, 32'h0);
      chk(rd, (32'(scan_pkg::CHAN_RESET) << scan_pkg::STAT_CHAN_LSB)
         | (32'(scan_pkg::COUNT_RESET) << scan_pkg::STAT_COUNT_LSB));
      wb(1'b1, 4'hC, 4'hF, 32'hFFFFFFFF);
      wb(1'b0, 4'hC, 4'hF, 32'h0);
      chk(rd, 32'h0);
      // frozen clock enable: the request waits, then lands once released
      ce_i <= 1'b0;
      mask = 16'hA5A5;
      fork
         wb(1'b1, scan_pkg::SCAN_SELECT_LOW_OFS, 4'h3, {16'h0, mask});
         begin
            repeat (6) begin
               @(posedge clk_i);
               chk(32'(ack_o), 32'h0);
            end
            ce_i <= 1'b1;
         end
      join
      wb(1'b0, scan_pkg::SCAN_SELECT_LOW_OFS, 4'hF, 32'h0);
      chk(rd, {16'h0, mask});
      for (int r = 0; r < 10; r++) begin
         seed = xs(seed);
         wb(1'b1, 4'h0, seed[3:0], seed);
         mask = {seed[1] ? seed[15:8] : mask[15:8],
                 seed[0] ? seed[7:0] : mask[7:0]};
         wb(1'b0, 4'h0, 4'hF, 32'h0);
         chk(rd, {16'h0, mask});
         mask = r < 4 ? CORNER[r] : seed[31:16] | 16'h0010;
         wb(1'b1, 4'h0, 4'hF, {~mask, mask});
         wb(1'b1, scan_pkg::SCAN_CTRL_OFS, 4'hF, 32'h1);
         wb(1'b0, scan_pkg::SCAN_CTRL_OFS, 4'hF, 32'h0);
         chk(rd, 32'h1 << scan_pkg::CTRL_ENABLE_BIT);
         n = starts + 20;
         for (k = 0; k < 3000 && starts < n; k++) @(posedge clk_i);
         wb(1'b1, scan_pkg::SCAN_CTRL_OFS, 4'hF, 32'h0);
         k = 0;
         do begin
            wb(1'b0, scan_pkg::SCAN_STATUS_OFS, 4'hF, 32'h0);
            k++;
         end while (rd[4] !== 1'b0 && k < 100);
         if (k == 100 || starts < n) begin
            fails++;
            stop_test;
         end
         chk(32'(rd[3:0]), 32'(cur));
         chk(32'(rd[5]), 32'(cur >= NIN));
         chk(32'(rd[15:8]), 32'(wraps));
      end
      stop_test;
   end
endmodule // tb_adc_input_scan_select
`default_nettype wire

// ==== src/adc_input_scan_select.sv ====
`timescale 1ns/10ps
`default_nettype none
module adc_input_scan_select #(
   parameter int unsigned NUM_INPUTS = 16
) (
   // clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output var  logic [31:0] dat_o,
   output var  logic        ack_o,
   // converter side
   output var  logic        conv_start_o,
   output var  logic [3:0]  analog_input_n_o,
   output var  logic        low_reference_voltage_o,
   input  wire logic        conv_done_i
);
   // ==========================================================
   // state
   logic [15:0]            scan_input_mask;
   logic [15:0]            next_scan_input_mask;
   logic                   scan_enable;
   logic                   next_scan_enable;
   logic [31:0]            next_dat;
   logic                   next_ack;
   scan_pkg::seq_state_t   state;
   scan_pkg::seq_state_t   next_state;
   logic [3:0]             chan;
   logic [3:0]             next_chan;
   logic                   vref;
   logic                   next_vref;
   logic                   next_start;
   logic [7:0]             count;
   logic [7:0]             next_count;
   logic                   busy;

   scan_pick_if pk ();

   assign pk.mask = scan_input_mask;
   assign pk.cur  = chan;
   assign busy    = (state != scan_pkg::ST_IDLE);

   scan_picker u_picker (
      .p (pk.pick)
   );

   // ==========================================================
   // helpers
   // lanes without a select keep their old bits
   function automatic logic [15:0] merge_lanes(
      input logic [15:0] old_word,
      input logic [15:0] new_word,
      input logic [1:0]  lanes
   );
      logic [15:0] word;
      word = old_word;
      if (lanes[0])
         word[7:0] = new_word[7:0];
      if (lanes[1])
         word[15:8] = new_word[15:8];
      return word;
   endfunction

   // a slot above the fitted inputs has no pin behind it
   function automatic logic slot_missing(input logic [3:0] slot);
      return {28'h0, slot} >= NUM_INPUTS;
   endfunction

   // the pick lands at or below the current input only on a wrap
   function automatic logic wraps_round(
      input logic [3:0] pick,
      input logic [3:0] cur
   );
      return pick <= cur;
   endfunction

   function automatic logic [31:0] status_word(
      input logic [3:0] ch,
      input logic       bsy,
      input logic       low_ref,
      input logic [7:0] cnt
   );
      logic [31:0] word;
      word = 32'h0000_0000;
      word[scan_pkg::STAT_CHAN_LSB +: 4]  = ch;
      word[scan_pkg::STAT_BUSY_BIT]       = bsy;
      word[scan_pkg::STAT_VREF_BIT]       = low_ref;
      word[scan_pkg::STAT_COUNT_LSB +: 8] = cnt;
      return word;
   endfunction

   // ==========================================================
   // register bus
   // one wait state: ack follows the request by one edge, drops after
   always_comb begin
      logic req;
      req                  = cyc_i && stb_i && !ack_o;
      next_ack             = req;
      next_scan_input_mask = scan_input_mask;
      next_scan_enable     = scan_enable;
      next_dat             = 32'h0000_0000;
      if (req && we_i) begin
         unique case (adr_i)
            scan_pkg::SCAN_SELECT_LOW_OFS: begin
               // every bit stored even without a pin behind it
               next_scan_input_mask = merge_lanes(scan_input_mask,
                  dat_i[15:0], sel_i[1:0]);
            end
            scan_pkg::SCAN_CTRL_OFS: begin
               if (sel_i[0])
                  next_scan_enable = dat_i[scan_pkg::CTRL_ENABLE_BIT];
            end
            default: begin
               // unmapped or read-only: acknowledged, ignored
            end
         endcase
      end
      if (req && !we_i) begin
         unique case (adr_i)
            scan_pkg::SCAN_SELECT_LOW_OFS: begin
               next_dat[15:0] = scan_input_mask;
            end
            scan_pkg::SCAN_CTRL_OFS: begin
               next_dat[scan_pkg::CTRL_ENABLE_BIT] = scan_enable;
            end
            scan_pkg::SCAN_STATUS_OFS: begin
               next_dat = status_word(chan, busy, vref, count);
            end
            default: begin
               next_dat = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scan_input_mask <= scan_pkg::SCAN_SELECT_RESET;
         scan_enable     <= scan_pkg::CTRL_ENABLE_RESET;
         dat_o           <= 32'h0000_0000;
         ack_o           <= 1'b0;
      end else if (ce_i) begin
         scan_input_mask <= next_scan_input_mask;
         scan_enable     <= next_scan_enable;
         dat_o           <= next_dat;
         ack_o           <= next_ack;
      end
   end

   // ==========================================================
   // scan sequencer
   // the mask is sampled live, so a change takes effect at the next pick
   always_comb begin
      next_state = state;
      next_chan  = chan;
      next_vref  = vref;
      next_start = 1'b0;
      next_count = count;
      unique case (state)
         scan_pkg::ST_IDLE: begin
            // only selected inputs are ever picked
            if (scan_enable && pk.any) begin
               next_chan  = pk.next;
               // missing input: slot kept, low reference sampled
               next_vref  = slot_missing(pk.next);
               next_state = scan_pkg::ST_START;
            end
         end
         scan_pkg::ST_START: begin
            next_start = 1'b1;
            next_state = scan_pkg::ST_WAIT;
         end
         scan_pkg::ST_WAIT: begin
            if (conv_done_i) begin
               if (wraps_round(pk.next, chan))
                  next_count = count + 8'h01;
               next_state = scan_pkg::ST_IDLE;
            end
         end
         default: begin
            // a code without exactly one bit set: fall back to idle
            next_state = scan_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= scan_pkg::ST_IDLE;
         chan  <= scan_pkg::CHAN_RESET;
         vref  <= 1'b0;
         count <= scan_pkg::COUNT_RESET;
      end else if (ce_i) begin
         state <= next_state;
         chan  <= next_chan;
         vref  <= next_vref;
         count <= next_count;
      end
   end

   // ==========================================================
   // converter outputs, straight from flip-flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_start_o            <= 1'b0;
         analog_input_n_o        <= scan_pkg::CHAN_RESET;
         low_reference_voltage_o <= 1'b0;
      end else if (ce_i) begin
         conv_start_o            <= next_start;
         analog_input_n_o        <= next_chan;
         low_reference_voltage_o <= next_vref;
      end
   end
endmodule // adc_input_scan_select
`default_nettype wire

// ==== src/scan_pick_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface scan_pick_if;
   logic [15:0] mask;
   logic [3:0]  cur;
   logic [3:0]  next;
   logic        any;
   modport seq  (output mask, output cur, input next, input any);
   modport pick (input mask, input cur, output next, output any);
endinterface
`default_nettype wire

// ==== src/scan_picker.sv ====
`timescale 1ns/10ps
`default_nettype none
module scan_picker (
   scan_pick_if.pick p
);
   // ==========================================================
   // next selected input strictly after cur, wrapping round
   always_comb begin
      logic [3:0] idx;
      logic       found;
      idx     = p.cur;
      found   = 1'b0;
      p.next  = p.cur;
      for (int i = 1; i <= 16; i++) begin
         idx = p.cur + i[3:0];
         if (!found && p.mask[idx]) begin
            found  = 1'b1;
            p.next = idx;
         end
      end
      p.any = |p.mask;
   end
endmodule // scan_picker
`default_nettype wire

// ==== src/scan_pkg.sv ====
// What this block does
// - a set mask bit puts its analog input into the automatic scan
// - a clear mask bit skips its input; no conversion is started for it
// - mask bit x selects analog input x, for x from zero to fifteen
// - all sixteen mask bits stay writable and readable on smaller variants
// - a selected bit with no input still converts, sampling the low reference
`default_nettype none
package scan_pkg;
   // ==========================================================
   // sizes
   localparam int unsigned MASK_W  = 16;
   localparam int unsigned CHAN_W  = 4;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned ADDR_W  = 4;
   localparam int unsigned COUNT_W = 8;

   // ==========================================================
   // register byte offsets
   localparam logic [3:0] SCAN_SELECT_LOW_OFS = 4'h0;
   localparam logic [3:0] SCAN_CTRL_OFS       = 4'h4;
   localparam logic [3:0] SCAN_STATUS_OFS     = 4'h8;

   // ==========================================================
   // field positions
   localparam int unsigned CTRL_ENABLE_BIT   = 0;
   localparam int unsigned STAT_CHAN_LSB     = 0;
   localparam int unsigned STAT_BUSY_BIT     = 4;
   localparam int unsigned STAT_VREF_BIT     = 5;
   localparam int unsigned STAT_COUNT_LSB    = 8;

   // ==========================================================
   // values after reset
   localparam logic [15:0] SCAN_SELECT_RESET = 16'h0000;
   localparam logic        CTRL_ENABLE_RESET = 1'h0;
   localparam logic [3:0]  CHAN_RESET        = 4'hF;
   localparam logic [7:0]  COUNT_RESET       = 8'h00;

   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_START = 3'b010,
      ST_WAIT  = 3'b100
   } seq_state_t;
endpackage
`default_nettype wire
